//--- bench/four_port_gpio_registers_bench.sv
// self-checking bench for the four-port gpio block
`timescale 1ns/1ps
`default_nettype none
module four_port_gpio_registers_bench;
   logic        clk, rstn, legacy_mode, io_rd, io_wr, mem_load_op, mem_write_op, rvalid_r;
   logic [5:0]  io_addr;
   logic [6:0]  mem_addr;
   logic [7:0]  wdata, rdata_r, q;
   logic [31:0] pin_in, pin_out_r, pin_oe_n_r, pin_pullup_r;
   int          err_count, n_tests;
   gpio_four_port u_dut (.*);
   gpio_pins_model u_pins (.*);
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // count a compare, report a mismatch
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one access; read data is x unless valid came back
   task automatic acc(input bit m, w, input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      if (m) {mem_addr, mem_write_op, mem_load_op} <= {a, w, !w};
      else {io_addr, io_wr, io_rd} <= {a[5:0], w, !w};
      wdata <= d;
      @(posedge clk);
      {io_rd, io_wr, mem_load_op, mem_write_op} <= 4'h0;
      #1 q = rvalid_r === 1'b1 ? rdata_r : 8'hxx;
   endtask
   // reset with a given strap level
   task automatic rst(input logic lg);
      @(posedge clk);
      {rstn, legacy_mode} <= {1'b0, lg};
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      // strap takes two sync stages plus the pad register to reach port c
      repeat (4) @(posedge clk);
   endtask
   // every port through both maps, then pads and readback
   task automatic t_ports;
      logic [6:0] b;
      logic [7:0] v;
      for (int p = 0; p < 4; p++) begin
         b = 7'h10 + 7'(3 * p);
         v = 8'h5A + 8'(p);
         acc(0, 0, b + 7'h2, 0);
         chk("out reset", 0, q);
         acc(0, 0, b + 7'h1, 0);
         chk("dir reset", 0, q);
         acc(1, 1, b + 7'h22, v);
         acc(0, 1, b + 7'h1, 8'h0F);
         acc(1, 0, b + 7'h22, 0);
         chk("out data space", v, q);
         acc(0, 1, b, 8'hFF);
         acc(0, 0, b + 7'h1, 0);
         chk("dir back", 8'h0F, q);
         acc(0, 0, b, 0);
         chk("pin level", v, q);
         chk("oe", 8'hF0, pin_oe_n_r[24-8*p+:8]);
         chk("drive", v & 8'h0F, pin_out_r[24-8*p+:8]);
         chk("pulls", v & 8'hF0, pin_pullup_r[24-8*p+:8]);
      end
   endtask
   // global pull-up disable, spare bits read zero
   task automatic t_pud;
      acc(0, 1, 7'h30, 8'hFF);
      acc(1, 0, 7'h50, 0);
      chk("pud reg", 8'h04, q);
      chk("pulls off", 0, pin_pullup_r);
      acc(0, 0, 7'h19, 0);
      chk("floating a", 8'h0D, q);
      acc(0, 1, 7'h30, 8'h00);
      acc(1, 0, 7'h50, 0);
      chk("pud cleared", 0, q);
      chk("pulls back", 8'h50, pin_pullup_r[7:0]);
   endtask
   // unmapped io offset and data space outside the window
   task automatic t_unmapped;
      acc(0, 0, 7'h3F, 0);
      chk("unmapped io", 0, q);
      acc(1, 0, 7'h1B, 0);
      chk("below window", 8'hxx, q);
      acc(1, 0, 7'h60, 0);
      chk("above window", 8'hxx, q);
      acc(1, 1, 7'h12, 8'hFF);
      acc(0, 0, 7'h12, 0);
      chk("stray write", 8'h5A, q);
   endtask
   // legacy strap holds port c low whatever the latch says
   task automatic t_legacy;
      rst(1'b1);
      chk("legacy oe", 0, pin_oe_n_r[23:16]);
      acc(0, 1, 7'h15, 8'hFF);
      acc(0, 0, 7'h13, 0);
      chk("legacy pads", 0, q);
   endtask
   // verdict and end of run
   task automatic conclude;
      if (err_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // main sequence
   initial begin
      {rstn, legacy_mode, io_rd, io_wr, mem_load_op, mem_write_op} = 6'h0;
      {io_addr, mem_addr, wdata} = 21'h0;
      err_count = 0;
      n_tests = 0;
      rst(1'b0);
      t_ports;
      t_pud;
      t_unmapped;
      t_legacy;
      conclude;
   end
   // watchdog well beyond the roughly 110 cycles needed
   initial begin
      repeat (4000) @(posedge clk);
      err_count++;
      conclude;
   end
endmodule // four_port_gpio_registers_bench
bind gpio_four_port gpio_four_port_props u_props (.*);
`default_nettype wire

//--- bench/gpio_four_port_props.sv
// assertion checker on the four-port gpio block's ports
`timescale 1ns/1ps
`default_nettype none
module gpio_four_port_props (
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // strap and register access
   input wire logic        legacy_mode,
   input wire logic [5:0]  io_addr,
   input wire logic        io_rd,
   input wire logic        io_wr,
   input wire logic [6:0]  mem_addr,
   input wire logic        mem_load_op,
   input wire logic        mem_write_op,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata_r,
   input wire logic        rvalid_r,
   // pads
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out_r,
   input wire logic [31:0] pin_oe_n_r,
   input wire logic [31:0] pin_pullup_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // data-space address inside the mapped window
   wire mem_in = mem_addr >= 7'h20 && mem_addr <= 7'h5F;
   a_io_read_answer: assert property (io_rd |=> rvalid_r) else $error("io read lost");
   a_mem_read_answer: assert property (mem_load_op && mem_in && !io_wr |=> rvalid_r)
      else $error("mem read lost");
   a_no_stray_valid: assert property (!io_rd && !(mem_load_op && mem_in) |=> !rvalid_r)
      else $error("stray valid");
   a_drive_needs_dir: assert property ((pin_out_r & pin_oe_n_r) == 0) else $error("bad drive");
   a_pull_only_input: assert property ((pin_pullup_r & ~pin_oe_n_r) == 0)
      else $error("pull on output");
   a_pud_kills_pulls: assert property (io_wr && io_addr == 6'h30 && wdata[2] |-> ##2
      pin_pullup_r == 0) else $error("pull-up kept");
   a_dir_write_pins: assert property (io_wr && io_addr == 6'h1A |-> ##2
      pin_oe_n_r[7:0] == ~$past(wdata, 2)) else $error("dir not on pads");
   a_legacy_port_c: assert property ($past(legacy_mode, 3) && $past(rstn, 3) && $past(rstn, 2)
      && $past(rstn) |-> pin_oe_n_r[23:16] == 0 && pin_out_r[23:16] == 0)
      else $error("legacy port c");
   // main scenarios reached
   c_pud: cover property (io_wr && io_addr == 6'h30 && wdata[2]);
   c_mem_out: cover property (mem_load_op && !mem_in);
   c_legacy: cover property (legacy_mode && pin_oe_n_r[23:16] == 0);
endmodule // gpio_four_port_props
`default_nettype wire

//--- bench/gpio_pins_model.sv
// board-side model of the 32 package pads
`timescale 1ns/1ps
`default_nettype none
module gpio_pins_model (
   // pad controls from the block
   input  wire logic [31:0] pin_out_r,
   input  wire logic [31:0] pin_oe_n_r,
   input  wire logic [31:0] pin_pullup_r,
   // level on each pad; a released pad without pull-up sinks to the board pull-down
   output wire logic [31:0] pin_in
);
   assign pin_in = (~pin_oe_n_r & pin_out_r) | (pin_oe_n_r & pin_pullup_r);
endmodule // gpio_pins_model
`default_nettype wire

//--- core/gpio_defines.vh
// register offsets, field positions and reset values of the four-port gpio block
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH
`define IO_SPACE_LAST      6'h3F
`define DATA_SPACE_OFFSET  7'h20
`define OFS_PORT_D_IN      6'h10
`define OFS_PORT_D_DIR     6'h11
`define OFS_PORT_D_OUT     6'h12
`define OFS_PORT_C_IN      6'h13
`define OFS_PORT_C_DIR     6'h14
`define OFS_PORT_C_OUT     6'h15
`define OFS_PORT_B_IN      6'h16
`define OFS_PORT_B_DIR     6'h17
`define OFS_PORT_B_OUT     6'h18
`define OFS_PORT_A_IN      6'h19
`define OFS_PORT_A_DIR     6'h1A
`define OFS_PORT_A_OUT     6'h1B
`define OFS_SPECIAL_FN     6'h30
`define PUD_BIT            2
`define RST_OUT_LATCH      8'h00
`define RST_DIRECTION      8'h00
`define RST_SPECIAL_FN     8'h00
`define RST_PIN_SAMPLE     8'h00
`endif

//--- core/gpio_four_port.v
// four eight-bit gpio ports with direction, output latch, pin readback and pull-up control
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defines.vh"
module gpio_four_port #(
   parameter WIDTH = 8
) (
   // clock and reset
   input  wire             clk,
   input  wire             rstn,
   // legacy compatibility strap, may move at any time, synchronised before use
   input  wire             legacy_mode,
   // io-space access (in / out instructions)
   input  wire [5:0]       io_addr,
   input  wire             io_rd,
   input  wire             io_wr,
   // data-space access (mem_load_op / mem_write_op)
   input  wire [6:0]       mem_addr,
   input  wire             mem_load_op,
   input  wire             mem_write_op,
   // shared write data and read data
   input  wire [WIDTH-1:0] wdata,
   output reg  [WIDTH-1:0] rdata_r,
   output reg              rvalid_r,
   // pins, port a in bits 7:0 up to port d in bits 31:24
   input  wire [4*WIDTH-1:0] pin_in,
   output reg  [4*WIDTH-1:0] pin_out_r,
   output reg  [4*WIDTH-1:0] pin_oe_n_r,
   output reg  [4*WIDTH-1:0] pin_pullup_r
);
   // port indices inside the packed vectors; port a sits in the lowest
   // byte of every pad vector and port d in the highest, while the io
   // offsets run the other way, from port a at the top down to port d
   localparam [1:0] PA = 2'd0;
   localparam [1:0] PB = 2'd1;
   localparam [1:0] PC = 2'd2;
   localparam [1:0] PD = 2'd3;

   // register state: per-port latch and direction, the one stored
   // special-function bit, and the synchronised strap and pad levels
   reg  [WIDTH-1:0]   out_latch_r [0:3];   // pin_output_bit per port
   reg  [WIDTH-1:0]   dir_r       [0:3];   // pin_direction_bit per port
   reg  [WIDTH-1:0]   sfn_r;               // special function register, only pud held
   wire [4*WIDTH-1:0] pin_sync;            // synchronised pin_input_bit levels
   reg                legacy_meta_r;       // first strap stage, read only by the second
   reg                legacy_sync_r;       // strap level safe to use on clk

   // decoded access: one offset, one read and one write strobe;
   // both address spaces end up here, so every register compares one
   // six-bit offset only
   reg  [5:0]         acc_ofs;
   reg                acc_rd;
   reg                acc_wr;
   reg  [6:0]         mem_rel;

   // merge both address spaces onto the io offset
   // - io strobes win when both spaces strobe in the same cycle
   // - data space only answers inside its 64-byte window above 0x20;
   //   the io offset is simply the address minus that base
   // - outside the window no strobe is raised, so no read answer comes back
   // - io offsets with no register behind them read as zero and
   //   swallow writes, see the read mux default
   always @* begin
      mem_rel = mem_addr - `DATA_SPACE_OFFSET;
      // defaults: no access this cycle
      acc_ofs = 6'h00;
      acc_rd  = 1'b0;
      acc_wr  = 1'b0;
      if (io_rd || io_wr) begin
         // io space covers every six-bit offset
         acc_ofs = io_addr;
         acc_rd  = io_rd;
         acc_wr  = io_wr;
      end else if ((mem_load_op || mem_write_op) && mem_addr >= `DATA_SPACE_OFFSET
                   && mem_rel <= {1'b0, `IO_SPACE_LAST}) begin
         // window base removed; the io offset is the low six bits
         acc_ofs = mem_rel[5:0];
         acc_rd  = mem_load_op;
         acc_wr  = mem_write_op;
      end
   end

   // synchronise all 32 pin inputs before readback; the pads are not
   // related to clk, so a read returns the level the pads had about two
   // clocks before the read strobe
   gpio_pin_sync #(
      .WIDTH       (4*WIDTH)
   ) u_sync (
      .clk         (clk),
      .rstn        (rstn),
      .pin_raw     (pin_in),
      .pin_level_r (pin_sync)
   );

   // the legacy strap is a pad like any other and may move at any time,
   // so it crosses two stages before the port c override looks at it;
   // port c therefore stays released for the first two edges after
   // reset, and with no clock running it is not driven at all
   // - the override follows the strap level, it is not latched once
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         legacy_meta_r <= 1'b0;
         legacy_sync_r <= 1'b0;
      end else begin
         legacy_meta_r <= legacy_mode;
         legacy_sync_r <= legacy_meta_r;
      end
   end

   // shared special-function register, only the pull-up disable bit is stored;
   // the remaining bits belong to the timer prescalers, which live outside
   // this block, so here they are dropped on write and read back as zero
   // - a read returns the stored bit in its place and zero elsewhere
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sfn_r <= `RST_SPECIAL_FN;
      end else if (acc_wr && acc_ofs == `OFS_SPECIAL_FN) begin
         sfn_r <= `RST_SPECIAL_FN;
         sfn_r[`PUD_BIT] <= wdata[`PUD_BIT];
      end
   end

   // one copy of the register pair and the pad drivers per port;
   // the copies differ only in their offsets and, for port c, in the
   // legacy override
   genvar p;
   generate
      for (p = 0; p < 4; p = p + 1) begin : g_port
         // io offsets of this port: pin level, direction, output latch;
         // each port takes three consecutive offsets, and the ports step
         // down by three from port a to port d
         localparam integer OFS_IN_I = `OFS_PORT_A_IN - 3 * p;
         wire [5:0] ofs_in  = OFS_IN_I[5:0];
         wire [5:0] ofs_dir = ofs_in + 6'd1;
         wire [5:0] ofs_out = ofs_in + 6'd2;

         // latch and direction writes; pin register is read-only, so a
         // write to its offset matches neither compare and is lost
         // - after reset every pin is an input with no pull-up
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               out_latch_r[p] <= `RST_OUT_LATCH;
               dir_r[p]       <= `RST_DIRECTION;
            end else begin
               if (acc_wr && acc_ofs == ofs_out) begin
                  out_latch_r[p] <= wdata;
               end
               if (acc_wr && acc_ofs == ofs_dir) begin
                  dir_r[p] <= wdata;
               end
            end
         end

         // pin drivers; legacy mode forces port c to drive zero
         // - all three pad controls are registered so the pads never see
         //   decode glitches, and they follow a register write one edge later
         // - a pull-up is only offered to an input whose latch bit is one,
         //   and the global disable bit takes it away from every port
         // - outside legacy mode port c behaves like the other three ports
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               pin_out_r[p*WIDTH +: WIDTH]    <= {WIDTH{1'b0}};
               // reset values are constants, the strap is not known yet,
               // so every port, port c included, starts released
               pin_oe_n_r[p*WIDTH +: WIDTH]   <= {WIDTH{1'b1}};
               pin_pullup_r[p*WIDTH +: WIDTH] <= {WIDTH{1'b0}};
            end else if (p == PC && legacy_sync_r) begin
               pin_out_r[p*WIDTH +: WIDTH]    <= {WIDTH{1'b0}};
               pin_oe_n_r[p*WIDTH +: WIDTH]   <= {WIDTH{1'b0}};
               pin_pullup_r[p*WIDTH +: WIDTH] <= {WIDTH{1'b0}};
            end else begin
               pin_out_r[p*WIDTH +: WIDTH]    <= out_latch_r[p] & dir_r[p];
               pin_oe_n_r[p*WIDTH +: WIDTH]   <= ~dir_r[p];
               pin_pullup_r[p*WIDTH +: WIDTH] <= out_latch_r[p] & ~dir_r[p]
                                                 & {WIDTH{~sfn_r[`PUD_BIT]}};
            end
         end
      end
   endgenerate

   // read mux: registered data, one cycle after the strobe
   // - rdata_r keeps the last value read until the next read strobe
   // - rvalid_r is high for exactly one cycle per accepted read
   // - pin levels come from the synchroniser, never straight from pads
   // - an unmapped offset still answers, with zero
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r  <= {WIDTH{1'b0}};
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= acc_rd;
         if (acc_rd) begin
            case (acc_ofs)
               `OFS_PORT_A_OUT: rdata_r <= out_latch_r[PA];
               `OFS_PORT_A_DIR: rdata_r <= dir_r[PA];
               `OFS_PORT_A_IN:  rdata_r <= pin_sync[PA*WIDTH +: WIDTH];
               `OFS_PORT_B_OUT: rdata_r <= out_latch_r[PB];
               `OFS_PORT_B_DIR: rdata_r <= dir_r[PB];
               `OFS_PORT_B_IN:  rdata_r <= pin_sync[PB*WIDTH +: WIDTH];
               `OFS_PORT_C_OUT: rdata_r <= out_latch_r[PC];
               `OFS_PORT_C_DIR: rdata_r <= dir_r[PC];
               `OFS_PORT_C_IN:  rdata_r <= pin_sync[PC*WIDTH +: WIDTH];
               `OFS_PORT_D_OUT: rdata_r <= out_latch_r[PD];
               `OFS_PORT_D_DIR: rdata_r <= dir_r[PD];
               `OFS_PORT_D_IN:  rdata_r <= pin_sync[PD*WIDTH +: WIDTH];
               `OFS_SPECIAL_FN: rdata_r <= sfn_r;
               default:         rdata_r <= {WIDTH{1'b0}};
            endcase
         end
      end
   end
endmodule // gpio_four_port
`default_nettype wire

//--- core/gpio_pin_sync.v
// two-flop synchroniser for the pin levels, instanced once for all 32 pins
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_sync #(
   parameter WIDTH = 8
) (
   // clock and reset
   input  wire             clk,
   input  wire             rstn,
   // raw pins in, synchronised levels out
   input  wire [WIDTH-1:0] pin_raw,
   output reg  [WIDTH-1:0] pin_level_r
);
   reg [WIDTH-1:0] meta_r;   // first stage, read only by second stage

   // two stages so the readback never sees a metastable level
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r      <= {WIDTH{1'b0}};
         pin_level_r <= {WIDTH{1'b0}};
      end else begin
         meta_r      <= pin_raw;
         pin_level_r <= meta_r;
      end
   end
endmodule // gpio_pin_sync
`default_nettype wire
